/* File: hdl/quadrature_io_map.svh */
// register map, field positions and constants of the encoder input block
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef QUADRATURE_IO_MAP_SVH
`define QUADRATURE_IO_MAP_SVH

// ****************************************************************
// bus and datapath widths
// ****************************************************************
`define QIO_ADR_W          8
`define QIO_DAT_W          32
`define QIO_SEL_W          4
`define QIO_CNT_W          32
`define QIO_IOC_W          16

// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define QIO_IOC_OFFSET     8'h00
`define QIO_IOC_RESET      16'h0000
`define QIO_IOC_WR_MASK    16'hFFF0

// ****************************************************************
// field positions of encoder_io_control
// ****************************************************************
`define QIO_CAPTURE_BIT    15
`define QIO_FILTER_EN_BIT  14
`define QIO_DIV_HI         13
`define QIO_DIV_LO         11
`define QIO_FUNC_HI        10
`define QIO_FUNC_LO        9
`define QIO_SWAP_BIT       8
`define QIO_POL_HI         7
`define QIO_POL_LO         4
`define QIO_STAT_HI        3
`define QIO_STAT_LO        0

// ****************************************************************
// filter
// ****************************************************************
`define QIO_DIV_CNT_W      7
`define QIO_FLT_DEPTH      3
`define QIO_INPUTS         4

`endif

/* File: hdl/quadrature_io_pkg.sv */
// types shared by the encoder input conditioning block
// assumes quadrature_io_map.svh is on the include path
package quadrature_io_pkg;

   // ****************************************************************
   // compare output modes
   // ****************************************************************
   typedef enum logic [1:0] {
      CMP_OFF,
      CMP_GREATER_EQUAL,
      CMP_LESS_EQUAL,
      CMP_WINDOW
   } compare_function_t;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage : quadrature_io_pkg

/* File: hdl/quadrature_input_conditioning.sv */
// encoder input conditioning: polarity, noise filter, a/b swap, compare output
// assumes a classic wishbone master on clk_i and pins already synchronous to clk_i
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`include "quadrature_io_map.svh"

module quadrature_input_conditioning (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`QIO_ADR_W-1:0]  wb_adr_i,
   input  wire logic [`QIO_SEL_W-1:0]  wb_sel_i,
   input  wire logic [`QIO_DAT_W-1:0]  wb_dat_i,
   output logic      [`QIO_DAT_W-1:0]  wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   phase_a_input_i,
   input  wire logic                   phase_b_input_i,
   input  wire logic                   index_input_i,
   input  wire logic                   home_input_i,
   input  wire logic [`QIO_CNT_W-1:0]  position_count_i,
   input  wire logic [`QIO_CNT_W-1:0]  greater_equal_compare_value_i,
   input  wire logic [`QIO_CNT_W-1:0]  less_equal_compare_value_i,
   output logic                        phase_a_o,
   output logic                        phase_b_o,
   output logic                        index_o,
   output logic                        home_o,
   output logic                        compare_output_pin_o,
   output logic                        capture_enable_o
);
   import quadrature_io_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // low bits of the divider that must all be one for a sample tick
   function automatic logic [`QIO_DIV_CNT_W-1:0] divider_mask(input logic [2:0] code);
      divider_mask = `QIO_DIV_CNT_W'((8'h01 << code) - 8'h01);
   endfunction : divider_mask

   // ****************************************************************
   // control register
   // ****************************************************************
   logic [`QIO_IOC_W-1:0]     ioc_reg;
   logic [`QIO_INPUTS-1:0]    polar_reg;
   bus_state_t                bus_reg;
   logic                      hit;
   logic                      req;

   assign req = wb_cyc_i && wb_stb_i && (bus_reg == BUS_IDLE);
   assign hit = (wb_adr_i == `QIO_IOC_OFFSET);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ioc_reg <= `QIO_IOC_RESET;
      end else if (req && wb_we_i && hit) begin
         // status nibble is not writable
         if (wb_sel_i[0]) begin
            ioc_reg[7:0] <= (wb_dat_i[7:0] & 8'(`QIO_IOC_WR_MASK));
         end
         if (wb_sel_i[1]) begin
            ioc_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_reg <= BUS_IDLE;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_reg <= BUS_ACK;
               end
            end
            BUS_ACK: begin
               bus_reg <= BUS_IDLE;
            end
            default: begin
               bus_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            // unmapped addresses still answer, reading zero
            if (hit) begin
               wb_dat_o <= {16'h0000, ioc_reg[15:4], polar_reg};
            end else begin
               wb_dat_o <= '0;
            end
         end
      end
   end

   // ****************************************************************
   // polarity
   // ****************************************************************
   logic [`QIO_INPUTS-1:0]    raw;
   assign raw = {home_input_i, index_input_i, phase_b_input_i, phase_a_input_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         polar_reg <= '0;
      end else begin
         polar_reg <= raw ^ ioc_reg[`QIO_POL_HI:`QIO_POL_LO];
      end
   end

   // ****************************************************************
   // noise filter
   // ****************************************************************
   logic [`QIO_DIV_CNT_W-1:0] div_reg;
   logic                      tick;
   logic [`QIO_FLT_DEPTH-1:0] hist_reg [`QIO_INPUTS];
   logic [`QIO_INPUTS-1:0]    filt_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + `QIO_DIV_CNT_W'(1);
      end
   end

   // one tick every 2^code clocks, code 000 samples every clock
   assign tick = ((div_reg & divider_mask(ioc_reg[`QIO_DIV_HI:`QIO_DIV_LO]))
                  == divider_mask(ioc_reg[`QIO_DIV_HI:`QIO_DIV_LO]));

   // a level must hold for three sample ticks before it passes on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `QIO_INPUTS; i++) begin
            hist_reg[i] <= '0;
         end
         filt_reg <= '0;
      end else if (!ioc_reg[`QIO_FILTER_EN_BIT]) begin
         filt_reg <= polar_reg;
         // history tracks the bypassed level, so enabling the filter makes no false edge
         for (int i = 0; i < `QIO_INPUTS; i++) begin
            hist_reg[i] <= {`QIO_FLT_DEPTH{polar_reg[i]}};
         end
      end else if (tick) begin
         for (int i = 0; i < `QIO_INPUTS; i++) begin
            hist_reg[i] <= {hist_reg[i][`QIO_FLT_DEPTH-2:0], polar_reg[i]};
            if (&hist_reg[i]) begin
               filt_reg[i] <= 1'b1;
            end else if (~|hist_reg[i]) begin
               filt_reg[i] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // phase swap and outputs
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_a_o <= 1'b0;
         phase_b_o <= 1'b0;
         index_o   <= 1'b0;
         home_o    <= 1'b0;
      end else begin
         if (ioc_reg[`QIO_SWAP_BIT]) begin
            phase_a_o <= filt_reg[1];
            phase_b_o <= filt_reg[0];
         end else begin
            phase_a_o <= filt_reg[0];
            phase_b_o <= filt_reg[1];
         end
         index_o <= filt_reg[2];
         home_o  <= filt_reg[3];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_enable_o <= 1'b0;
      end else begin
         capture_enable_o <= ioc_reg[`QIO_CAPTURE_BIT];
      end
   end

   // ****************************************************************
   // compare output
   // ****************************************************************
   logic cmp_ge;
   logic cmp_le;
   assign cmp_ge = (position_count_i >= greater_equal_compare_value_i);
   assign cmp_le = (position_count_i <= less_equal_compare_value_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_output_pin_o <= 1'b0;
      end else begin
         case (compare_function_t'(ioc_reg[`QIO_FUNC_HI:`QIO_FUNC_LO]))
            CMP_OFF:           compare_output_pin_o <= 1'b0;
            CMP_GREATER_EQUAL: compare_output_pin_o <= cmp_ge;
            CMP_LESS_EQUAL:    compare_output_pin_o <= cmp_le;
            CMP_WINDOW:        compare_output_pin_o <= cmp_ge && cmp_le;
            default:           compare_output_pin_o <= 1'b0;
         endcase
      end
   end

endmodule : quadrature_input_conditioning

/* File: verification/quadrature_encoder_model.sv */
// encoder model: gray-coded phases, index pulse at one position, home level
// assumes at most one step request per clock
module quadrature_encoder_model (
   input  wire logic clk_i,
   input  wire logic step_i,
   input  wire logic home_i,
   output logic      a_o,
   output logic      b_o,
   output logic      index_o,
   output logic      home_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pos_reg = 2'h0;
   always_ff @(posedge clk_i) begin
      if (step_i) begin
         pos_reg <= pos_reg + 2'h1;
      end
   end
   // phase a leads phase b when stepping up
   assign a_o     = pos_reg[1] ^ pos_reg[0];
   assign b_o     = pos_reg[1];
   assign index_o = pos_reg == 2'h2;
   assign home_o  = home_i;
endmodule : quadrature_encoder_model

/* File: verification/quadrature_input_conditioning_sva.sv */
// checker for the encoder input block, bound to its top ports
// assumes masters write lanes 0 and 1 together
module quadrature_input_conditioning_sva (
   input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o, position_count_i,
   input wire logic [31:0] greater_equal_compare_value_i, less_equal_compare_value_i,
   input wire logic        phase_a_input_i, phase_b_input_i, index_input_i, home_input_i,
   input wire logic        phase_a_o, phase_b_o, index_o, home_o, compare_output_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] ctrl_reg;
   logic [2:0]  quiet_reg;
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == 8'h00);
   wire [3:0] e = {home_input_i, index_input_i, phase_b_input_i, phase_a_input_i} ^ ctrl_reg[7:4];
   always_ff @(posedge clk_i) begin
      if (rst_i) ctrl_reg <= 16'h0000;
      else if (wr) ctrl_reg <= wb_dat_i[15:0] & 16'hfff0;
   end
   // pipeline settles only some cycles after a control change
   always_ff @(posedge clk_i) begin
      if (rst_i || wr) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
   end
   function automatic logic f(logic [1:0] m, logic [31:0] p, g, l);
      return (m != 2'h0) & (m[0] ? p >= g : 1'b1) & (m[1] ? p <= l : 1'b1);
   endfunction : f
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a one-cycle pulse");
   AST_CMP: assert property (compare_output_pin_o == f($past(ctrl_reg[10:9]),
      $past(position_count_i), $past(greater_equal_compare_value_i),
      $past(less_equal_compare_value_i))) else $error("compare output wrong");
   AST_POL: assert property (quiet_reg == 3'h7 && !ctrl_reg[14]
      |-> {home_o, index_o} == $past(e[3:2], 3)) else $error("home or index level wrong");
   AST_SWAP: assert property (quiet_reg == 3'h7 && !ctrl_reg[14] |-> {phase_b_o, phase_a_o}
      == (ctrl_reg[8] ? {$past(e[0], 3), $past(e[1], 3)} : $past(e[1:0], 3)))
      else $error("phase routing wrong");
   AST_STAT: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00
      |-> wb_dat_o == {16'h0000, $past(ctrl_reg[15:4]), $past(e, 2)}) else $error("readback wrong");
   AST_FILT: assert property ($changed(home_o) && ctrl_reg[14] && ctrl_reg[13:11] != 3'h0
      && quiet_reg == 3'h7 |=> $stable(home_o)) else $error("filtered output off tick");
endmodule : quadrature_input_conditioning_sva
bind quadrature_input_conditioning quadrature_input_conditioning_sva i_sva (.*);

/* File: verification/quadrature_input_conditioning_bench.sv */
// self-checking bench for the encoder input block
// assumes the design answers every bus request within the watchdog span
module quadrature_input_conditioning_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import quadrature_io_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, step = 0, hm = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0000_0000, position_count_i = 32'h0000_0000, wb_dat_o, rdat;
   logic [31:0] greater_equal_compare_value_i = 32'h0000_0064;
   logic [31:0] less_equal_compare_value_i    = 32'h0000_00c8;
   logic wb_ack_o, phase_a_input_i, phase_b_input_i, index_input_i, home_input_i;
   logic phase_a_o, phase_b_o, index_o, home_o, compare_output_pin_o, capture_enable_o;
   int bad_count = 0, cmp_count = 0, lat;
   int tv[4] = '{99, 100, 200, 201};
   always #2 clk_i = ~clk_i;
   quadrature_encoder_model i_enc (.clk_i(clk_i), .step_i(step), .home_i(hm),
      .a_o(phase_a_input_i), .b_o(phase_b_input_i), .index_o(index_input_i),
      .home_o(home_input_i));
   quadrature_input_conditioning i_dut (.*);
   task check(input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : check
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : xfer
   task finish_test;
      $display("mismatches %0d compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      bad_count++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      xfer(0, 8'h00, 0); check(rdat, 32'h0000_0000);
      xfer(1, 8'h00, 32'h0000_ffff); xfer(0, 8'h00, 0); check(rdat, 32'h0000_ffff);
      check(capture_enable_o, 1);
      xfer(1, 8'h04, 0); xfer(0, 8'h04, 0); check(rdat, 0);
      xfer(0, 8'h00, 0); check(rdat, 32'h0000_ffff);
      xfer(1, 8'h00, 32'h0000_00f0); repeat (5) @(posedge clk_i);
      check({home_o, index_o, phase_b_o, phase_a_o}, 4'hf);
      step <= 1; @(posedge clk_i); step <= 0;
      xfer(1, 8'h00, 32'h0000_010f); repeat (5) @(posedge clk_i);
      check({phase_b_o, phase_a_o}, 2'h2);
      xfer(0, 8'h00, 0); check(rdat, 32'h0000_0101);
      xfer(1, 8'h00, 0); repeat (5) @(posedge clk_i);
      check({phase_b_o, phase_a_o}, 2'h1);
      for (int m = 0; m < 4; m++) begin
         xfer(1, 8'h00, 32'(m) << 9);
         for (int k = 0; k < 4; k++) begin
            position_count_i <= 32'(tv[k]);
            repeat (3) @(posedge clk_i);
            check(compare_output_pin_o, (m == 1 && tv[k] >= 100) || (m == 2 && tv[k] <= 200)
               || (m == 3 && tv[k] >= 100 && tv[k] <= 200));
         end
      end
      for (int d = 0; d < 8; d++) begin
         xfer(1, 8'h00, 32'h0000_4000 | (32'(d) << 11));
         hm <= !d[0];
         lat = 0;
         do begin @(posedge clk_i); lat++; end while (home_o !== !d[0] && lat < 2000);
         check(lat >= (3 << d), 1);
         check(lat <= (4 << d) + 8, 1);
      end
      finish_test;
   end
endmodule : quadrature_input_conditioning_bench
